// ===== verilog/eir_top.sv
// Extended_irq_control enable, priority and pending-flag registers on AHB-Lite
`timescale 1ns/1ns
`default_nettype none

// What this block does
// R1 - Enable bits gate radio, Timer2, crypto sources
// R2 - Timer3 enable at bit 3, resets zero
// R3 - Priority bit set means high level
// R4 - Priority bits placed per source, bit 7 zero
// R5 - Source event sets sticky pending flag
// R6 - Pending flags at bits 7-4, rest zero
// R7 - Sleep timer flag bit 3 at control register
// R8 - Sleep timer priority behaves like the others
// R9 - High requests first; writing zero clears flag

module eir_top
    import eir_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire eir_src_t SRC_EVENT,
    input wire logic SERIAL_PERIPH_REQ,
    input wire logic VOICE_REQ,
    output logic CORE_REQ_VALID,
    output logic CORE_REQ_HIGH,
    output logic [2:0] CORE_REQ_SOURCE,
    output logic IRQ
);

    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] prio;
        logic [7:0] pending;
        logic [7:0] ext_ctrl;
        eir_src_t evt_status;
        eir_src_t evt_mask;
        logic dp_write;
        logic [7:0] dp_idx;
        logic [31:0] rdata;
        logic hreadyout;
        logic hresp;
        eir_req_t req;
        logic irq;
    } eir_state_t;

    eir_state_t state_reg;
    eir_state_t state_next;

    logic addr_phase;
    logic addr_mapped;
    logic [7:0] addr_idx;
    logic [7:0] wr_byte;
    logic wr_pending;
    logic wr_ext_ctrl;
    logic wr_prio;
    logic wr_enable;
    logic wr_clear;
    logic wr_mask;
    eir_src_t core_req;
    eir_src_t prio_vec;
    eir_req_t sel;

    // Register index comes from the word address; upper bits must be zero
    assign addr_idx = HADDR[9:2];
    assign addr_mapped = (HADDR[31:10] == 22'h000000);

    // A transfer is taken only with the bus ready and the slave selected
    assign addr_phase = HSEL & HREADY &
        ((HTRANS == EIR_HTRANS_NONSEQ) | (HTRANS == EIR_HTRANS_SEQ));

    // Only whole words are issued; the registers sit in the low byte
    assign wr_byte = HWDATA[7:0];

    assign wr_pending = state_reg.dp_write & (state_reg.dp_idx == EIR_IDX_PENDING);
    assign wr_ext_ctrl = state_reg.dp_write & (state_reg.dp_idx == EIR_IDX_EXT_CTRL);
    assign wr_prio = state_reg.dp_write & (state_reg.dp_idx == EIR_IDX_PRIO);
    assign wr_enable = state_reg.dp_write & (state_reg.dp_idx == EIR_IDX_ENABLE);
    assign wr_clear = state_reg.dp_write & (state_reg.dp_idx == EIR_IDX_EVT_CLEAR);
    assign wr_mask = state_reg.dp_write & (state_reg.dp_idx == EIR_IDX_EVT_MASK);

    // Read data mux over the values that the current edge will store
    function automatic logic [31:0] read_mux(
        input logic [7:0] idx,
        input eir_state_t s
    );
        logic [31:0] d;
        d = 32'h00000000;
        case (idx)
            EIR_IDX_PENDING: begin
                d[7:0] = s.pending;
            end
            EIR_IDX_EXT_CTRL: begin
                d[7:0] = s.ext_ctrl;
            end
            EIR_IDX_PRIO: begin
                d[7:0] = s.prio;
            end
            EIR_IDX_ENABLE: begin
                d[7:0] = s.enable;
            end
            EIR_IDX_EVT_STATUS: begin
                d[6:0] = s.evt_status;
            end
            EIR_IDX_EVT_MASK: begin
                d[6:0] = s.evt_mask;
            end
            default: begin
                d = 32'h00000000;
            end
        endcase
        return d;
    endfunction

    // Requests that the core may see: pending and enabled
    always_comb begin
        core_req = EIR_RST_SRC;
        core_req.radio = state_reg.pending[EIR_FLG_RADIO_BIT] &
            state_reg.enable[EIR_EN_RADIO_BIT]; // see R1
        core_req.timer2 = state_reg.pending[EIR_FLG_TIMER2_BIT] &
            state_reg.enable[EIR_EN_TIMER2_BIT]; // see R1
        core_req.crypto = state_reg.pending[EIR_FLG_CRYPTO_BIT] &
            state_reg.enable[EIR_EN_CRYPTO_BIT]; // see R1
        core_req.timer3 = state_reg.pending[EIR_FLG_TIMER3_BIT] &
            state_reg.enable[EIR_EN_TIMER3_BIT]; // see R2
        // Enables of these three live in fields kept outside this block
        core_req.sleep_timer = state_reg.ext_ctrl[EIR_EXT_SLEEP_BIT];
        core_req.serial_periph = SERIAL_PERIPH_REQ;
        core_req.voice = VOICE_REQ;
    end

    // Priority register bits map one to one onto the source layout
    assign prio_vec = state_reg.prio[6:0]; // see R4

    eir_prio_sel u_sel (
        .req(core_req),
        .prio(prio_vec), // see R3
        .sel(sel)
    );

    always_comb begin
        state_next = state_reg;

        // Source enable register: only bits 3 to 0 are implemented
        if (wr_enable) begin
            state_next.enable = wr_byte & EIR_EN_MASK; // see R1
        end

        // Priority register, sleep timer bit included
        if (wr_prio) begin
            state_next.prio = wr_byte & EIR_PRIO_MASK; // see R3
        end

        // Pending flags: an event in the same cycle beats a software clear
        if (wr_pending) begin
            state_next.pending = EIR_RST_BYTE;
            state_next.pending[EIR_FLG_RADIO_BIT] = wr_byte[EIR_FLG_RADIO_BIT]; // see R9
            state_next.pending[EIR_FLG_TIMER2_BIT] = wr_byte[EIR_FLG_TIMER2_BIT];
            state_next.pending[EIR_FLG_CRYPTO_BIT] = wr_byte[EIR_FLG_CRYPTO_BIT];
            state_next.pending[EIR_FLG_TIMER3_BIT] = wr_byte[EIR_FLG_TIMER3_BIT]; // see R6
        end
        if (SRC_EVENT.radio) begin
            state_next.pending[EIR_FLG_RADIO_BIT] = 1'b1; // see R5
        end
        if (SRC_EVENT.timer2) begin
            state_next.pending[EIR_FLG_TIMER2_BIT] = 1'b1; // see R5
        end
        if (SRC_EVENT.crypto) begin
            state_next.pending[EIR_FLG_CRYPTO_BIT] = 1'b1; // see R5
        end
        if (SRC_EVENT.timer3) begin
            state_next.pending[EIR_FLG_TIMER3_BIT] = 1'b1; // see R6
        end

        // Extended control: only the sleep timer flag is stored
        if (wr_ext_ctrl) begin
            state_next.ext_ctrl = EIR_RST_BYTE;
            state_next.ext_ctrl[EIR_EXT_SLEEP_BIT] = wr_byte[EIR_EXT_SLEEP_BIT]; // see R7
        end
        if (SRC_EVENT.sleep_timer) begin
            state_next.ext_ctrl[EIR_EXT_SLEEP_BIT] = 1'b1; // see R7
        end

        // Event status: write-one-to-clear, then new events set again
        if (wr_clear) begin
            state_next.evt_status = state_reg.evt_status & ~wr_byte[6:0];
        end
        state_next.evt_status = state_next.evt_status | SRC_EVENT;

        if (wr_mask) begin
            state_next.evt_mask = wr_byte[6:0];
        end

        // Bus address phase; the slave never inserts wait states
        state_next.hreadyout = 1'b1;
        // Nothing on this bus is refused, so the response stays OKAY
        state_next.hresp = EIR_HRESP_OKAY;
        state_next.dp_write = 1'b0;
        state_next.dp_idx = EIR_RST_BYTE;
        if (addr_phase) begin
            state_next.dp_write = HWRITE & addr_mapped;
            state_next.dp_idx = addr_mapped ? addr_idx : EIR_RST_BYTE;
        end

        // Read data is taken from next values so a write just before is seen
        if (addr_phase & ~HWRITE & addr_mapped) begin
            state_next.rdata = read_mux(addr_idx, state_next);
        end else begin
            state_next.rdata = 32'h00000000;
        end

        // Core request and interrupt line
        state_next.req = sel; // see R8
        state_next.irq = |(state_next.evt_status & state_next.evt_mask);
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            state_reg.enable <= EIR_RST_BYTE;
            state_reg.prio <= EIR_RST_BYTE;
            state_reg.pending <= EIR_RST_BYTE;
            state_reg.ext_ctrl <= EIR_RST_BYTE;
            state_reg.evt_status <= EIR_RST_SRC;
            state_reg.evt_mask <= EIR_RST_SRC;
            state_reg.dp_write <= 1'b0;
            state_reg.dp_idx <= EIR_RST_BYTE;
            state_reg.rdata <= 32'h00000000;
            state_reg.hreadyout <= 1'b1;
            state_reg.hresp <= EIR_HRESP_OKAY;
            state_reg.req <= '0;
            state_reg.irq <= 1'b0;
        end else if (CE) begin
            state_reg <= state_next;
        end
    end

    assign HRDATA = state_reg.rdata;
    assign HREADYOUT = state_reg.hreadyout;
    assign HRESP = state_reg.hresp;
    assign CORE_REQ_VALID = state_reg.req.valid;
    assign CORE_REQ_HIGH = state_reg.req.high;
    assign CORE_REQ_SOURCE = state_reg.req.source;
    assign IRQ = state_reg.irq;

endmodule

`default_nettype wire

// ===== pkg/eir_pkg.sv
// Package with register map, field layout and shared types of the extended_irq_control block
package eir_pkg;

    // Register indices; byte address on the bus is four times the index
    localparam logic [7:0] EIR_IDX_PENDING = 8'h91;
    localparam logic [7:0] EIR_IDX_EXT_CTRL = 8'hd8;
    localparam logic [7:0] EIR_IDX_PRIO = 8'hf8;
    localparam logic [7:0] EIR_IDX_ENABLE = 8'ha8;
    localparam logic [7:0] EIR_IDX_EVT_STATUS = 8'he0;
    localparam logic [7:0] EIR_IDX_EVT_CLEAR = 8'he1;
    localparam logic [7:0] EIR_IDX_EVT_MASK = 8'he2;

    // Source enable fields
    localparam int EIR_EN_RADIO_BIT = 0;
    localparam int EIR_EN_TIMER2_BIT = 1;
    localparam int EIR_EN_CRYPTO_BIT = 2;
    localparam int EIR_EN_TIMER3_BIT = 3;
    localparam logic [7:0] EIR_EN_MASK = 8'h0f;

    // Priority register: bit 7 reserved
    localparam logic [7:0] EIR_PRIO_MASK = 8'h7f;

    // Pending flag fields
    localparam int EIR_FLG_RADIO_BIT = 4;
    localparam int EIR_FLG_TIMER2_BIT = 5;
    localparam int EIR_FLG_CRYPTO_BIT = 6;
    localparam int EIR_FLG_TIMER3_BIT = 7;

    // Sleep timer flag in the extended control register
    localparam int EIR_EXT_SLEEP_BIT = 3;

    // Reset values
    localparam logic [7:0] EIR_RST_BYTE = 8'h00;
    localparam logic [6:0] EIR_RST_SRC = 7'h00;

    // AHB-Lite codes
    localparam logic [1:0] EIR_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] EIR_HTRANS_SEQ = 2'h3;
    localparam logic EIR_HRESP_OKAY = 1'b0;

    // One bit per interrupt source, laid out like the priority register
    typedef struct packed {
        logic voice;
        logic serial_periph;
        logic sleep_timer;
        logic timer3;
        logic crypto;
        logic timer2;
        logic radio;
    } eir_src_t;

    // Request presented to the processor core
    typedef struct packed {
        logic valid;
        logic high;
        logic [2:0] source;
    } eir_req_t;

endpackage

// ===== verilog/eir_prio_sel.sv
// Two-level priority selector over the interrupt sources
`timescale 1ns/1ns
`default_nettype none

module eir_prio_sel
    import eir_pkg::*;
(
    input wire eir_src_t req,
    input wire eir_src_t prio,
    output eir_req_t sel
);

    logic [6:0] hi_req;
    logic [6:0] lo_req;
    logic [7:0] hi_seen;
    logic [7:0] lo_seen;
    logic [6:0] hi_pick;
    logic [6:0] lo_pick;
    logic [6:0] pick;

    assign hi_seen[0] = 1'b0;
    assign lo_seen[0] = 1'b0;

    // Lowest index wins inside a level
    genvar i;
    generate
        for (i = 0; i < 7; i = i + 1) begin : g_src
            assign hi_req[i] = req[i] & prio[i];
            assign lo_req[i] = req[i] & ~prio[i];
            assign hi_pick[i] = hi_req[i] & ~hi_seen[i];
            assign lo_pick[i] = lo_req[i] & ~lo_seen[i];
            assign hi_seen[i + 1] = hi_seen[i] | hi_req[i];
            assign lo_seen[i + 1] = lo_seen[i] | lo_req[i];
        end
    endgenerate

    // High level blocks any low-level request
    assign pick = hi_seen[7] ? hi_pick : lo_pick; // see R9

    always_comb begin
        sel.valid = hi_seen[7] | lo_seen[7];
        sel.high = hi_seen[7];
        sel.source = 3'h0;
        for (int k = 0; k < 7; k++) begin
            if (pick[k]) begin
                sel.source = 3'(k);
            end
        end
    end

endmodule

`default_nettype wire

// ===== verification/eir_top_sva.sv
// Port checker for the extended_irq_control block
`timescale 1ns/1ns
`default_nettype none
module eir_top_sva
    import eir_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire eir_src_t SRC_EVENT,
    input wire logic SERIAL_PERIPH_REQ,
    input wire logic CORE_REQ_VALID
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    sequence s_take;
        CE && HSEL && HREADY && HTRANS[1] && !HWRITE;
    endsequence
    sequence s_rd(i);
        s_take and HADDR == {22'h0, i, 2'h0};
    endsequence
    property p_pend_rsv;
        s_rd(EIR_IDX_PENDING) |=> (HRDATA & 32'hffffff0f) == 32'h0;
    endproperty
    a_pend_rsv: assert property (p_pend_rsv) else $error("pending reserved bits set");
    property p_ext_rsv;
        s_rd(EIR_IDX_EXT_CTRL) |=> (HRDATA & 32'hfffffff7) == 32'h0;
    endproperty
    a_ext_rsv: assert property (p_ext_rsv) else $error("control reserved bits set");
    property p_prio_rsv;
        s_rd(EIR_IDX_PRIO) |=> (HRDATA & 32'hffffff80) == 32'h0;
    endproperty
    a_prio_rsv: assert property (p_prio_rsv) else $error("priority bit 7 set");
    property p_en_rsv;
        s_rd(EIR_IDX_ENABLE) |=> (HRDATA & 32'hfffffff0) == 32'h0;
    endproperty
    a_en_rsv: assert property (p_en_rsv) else $error("enable upper bits set");
    property p_sleep_req;
        CE && SRC_EVENT.sleep_timer ##1 CE |=> CORE_REQ_VALID;
    endproperty
    a_sleep_req: assert property (p_sleep_req) else $error("sleep event not requested");
    property p_spi_req;
        (CE && SERIAL_PERIPH_REQ) [*2] |=> CORE_REQ_VALID;
    endproperty
    a_spi_req: assert property (p_spi_req) else $error("spi level not requested");
    property p_okay;
        HREADYOUT && !HRESP;
    endproperty
    a_okay: assert property (p_okay) else $error("bus not ready or not okay");
    property p_rd_idle;
        CE && !(HSEL && HREADY && HTRANS[1] && !HWRITE) |=> HRDATA == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
    property p_ce_hold;
        !CE |=> $stable(HRDATA) && $stable(CORE_REQ_VALID);
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("outputs moved with clock enable low");
endmodule
bind eir_top eir_top_sva u_sva (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SRC_EVENT(SRC_EVENT),
    .SERIAL_PERIPH_REQ(SERIAL_PERIPH_REQ), .CORE_REQ_VALID(CORE_REQ_VALID));
`default_nettype wire

// ===== verification/eir_src_model.sv
// Peripheral sources at the far side: event strobes and request levels
`timescale 1ns/1ns
`default_nettype none
module eir_src_model
    import eir_pkg::*;
(
    input wire logic clk,
    input wire eir_src_t fire,
    input wire logic spi_on,
    input wire logic voice_on,
    output eir_src_t event_out = '0,
    output logic spi_req = 1'b0,
    output logic voice_req = 1'b0
);
    // Events are one-cycle strobes; a held fire gives a held level
    always_ff @(posedge clk) begin
        event_out <= fire;
        spi_req <= spi_on;
        voice_req <= voice_on;
    end
endmodule
`default_nettype wire

// ===== verification/eir_top_tb.sv
// Self-checking bench for the extended_irq_control block
`timescale 1ns/1ns
`default_nettype none
module eir_top_tb
    import eir_pkg::*;
;
    logic mclk = 0, rst_n = 0, ce = 1, hsel = 0, hwrite = 0, spi_on = 0, voice_on = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic hrdy, hresp, spi_req, voice_req, cv, ch, irq;
    logic [2:0] cs;
    eir_src_t fire = '0, ev;
    int num_errors = 0, cmp_count = 0;
    logic [7:0] idx_t [5] = '{EIR_IDX_PENDING, EIR_IDX_EXT_CTRL, EIR_IDX_PRIO,
        EIR_IDX_ENABLE, EIR_IDX_EVT_MASK};
    logic [7:0] msk_t [5] = '{8'hf0, 8'h08, 8'h7f, 8'h0f, 8'h7f};
    always #5 mclk = ~mclk;
    eir_src_model u_src (.clk(mclk), .fire(fire), .spi_on(spi_on), .voice_on(voice_on),
        .event_out(ev), .spi_req(spi_req), .voice_req(voice_req));
    eir_top u_dut (.MCLK(mclk), .RESET_N(rst_n), .CE(ce), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
        .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .SRC_EVENT(ev),
        .SERIAL_PERIPH_REQ(spi_req), .VOICE_REQ(voice_req), .CORE_REQ_VALID(cv),
        .CORE_REQ_HIGH(ch), .CORE_REQ_SOURCE(cs), .IRQ(irq));
    task automatic end_of_test();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Timeout guards every wait for the slave
    task automatic edge_rdy();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hrdy !== 1'b1 && n < 50);
        if (hrdy !== 1'b1) begin
            num_errors++;
            end_of_test();
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] i, input logic [7:0] d,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= EIR_HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {22'h0, i, 2'h0};
        edge_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        edge_rdy();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [31:0] x;
        xfer(1'b1, i, d, x);
    endtask
    task automatic rdc(input logic [7:0] i, input logic [7:0] e);
        logic [31:0] x;
        xfer(1'b0, i, 8'h0, x);
        chk(x, {24'h0, e});
    endtask
    // High level first, lowest index within a level
    function automatic logic [3:0] pick(logic [6:0] r, logic [6:0] p);
        for (int i = 0; i < 7; i++) if (r[i] && p[i]) return {1'b1, 3'(i)};
        for (int i = 0; i < 7; i++) if (r[i]) return {1'b0, 3'(i)};
        return 4'h0;
    endfunction
    function automatic logic [7:0] pend_of(int s);
        return (s < 4) ? 8'h10 << s : 8'h00;
    endfunction
    initial begin
        logic [7:0] dv [5];
        logic [6:0] r;
        void'($urandom(32'h8303627e));
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        for (int j = 0; j < 5; j++) rdc(idx_t[j], 8'h00);
        rdc(8'h00, 8'h00);
        for (int k = 0; k < 16; k++) begin
            spi_on <= (k > 1) ? 1'($urandom) : 1'b0;
            voice_on <= (k > 1) ? 1'($urandom) : 1'b0;
            for (int j = 0; j < 5; j++) begin
                dv[j] = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
                wr(idx_t[j], dv[j]);
            end
            for (int j = 0; j < 5; j++) rdc(idx_t[j], dv[j] & msk_t[j]);
            r = {voice_on, spi_on, dv[1][3], dv[0][7:4] & dv[3][3:0]};
            repeat (2) @(posedge mclk);
            if (|r) chk({cv, ch, cs}, {1'b1, pick(r, dv[2][6:0])});
            else chk(cv, 1'b0);
        end
        spi_on <= 1'b0;
        voice_on <= 1'b0;
        wr(EIR_IDX_PENDING, 8'h00);
        wr(EIR_IDX_EXT_CTRL, 8'h00);
        wr(EIR_IDX_EVT_MASK, 8'h7f);
        for (int s = 0; s < 7; s++) begin
            fire <= eir_src_t'(7'h1 << s);
            @(posedge mclk);
            fire <= '0;
            repeat (2) @(posedge mclk);
            rdc(EIR_IDX_PENDING, pend_of(s));
            rdc(EIR_IDX_EXT_CTRL, (s == 4) ? 8'h08 : 8'h00);
            rdc(EIR_IDX_EVT_STATUS, 8'h1 << s);
            chk(irq, 1'b1);
            wr(EIR_IDX_EVT_CLEAR, 8'h1 << s);
            @(posedge mclk);
            chk(irq, 1'b0);
            wr(EIR_IDX_PENDING, 8'h00);
            wr(EIR_IDX_EXT_CTRL, 8'h00);
            rdc(EIR_IDX_PENDING, 8'h00);
        end
        wr(EIR_IDX_EVT_MASK, 8'h00);
        fire <= '1;
        @(posedge mclk);
        fire <= '0;
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        rdc(EIR_IDX_EVT_STATUS, 8'h7f);
        rdc(EIR_IDX_EVT_CLEAR, 8'h00);
        wr(EIR_IDX_EVT_MASK, 8'h7f);
        @(posedge mclk);
        chk(irq, 1'b1);
        wr(EIR_IDX_EVT_CLEAR, 8'hff);
        @(posedge mclk);
        chk(irq, 1'b0);
        // Clock enable low: events that arrive meanwhile are not stored
        wr(EIR_IDX_PENDING, 8'h00);
        wr(EIR_IDX_EXT_CTRL, 8'h00);
        ce <= 1'b0;
        fire <= '1;
        @(posedge mclk);
        fire <= '0;
        repeat (3) @(posedge mclk);
        ce <= 1'b1;
        rdc(EIR_IDX_PENDING, 8'h00);
        rdc(EIR_IDX_EXT_CTRL, 8'h00);
        rdc(EIR_IDX_EVT_STATUS, 8'h00);
        chk(irq, 1'b0);
        // Event strobe lands on the same edge as a clearing write: set wins
        fire <= eir_src_t'(7'h01);
        fork
            wr(EIR_IDX_PENDING, 8'h00);
            begin
                @(posedge mclk);
                fire <= '0;
            end
        join
        rdc(EIR_IDX_PENDING, 8'h10);
        // Second reset in mid-run returns every register to zero
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        for (int j = 0; j < 5; j++) rdc(idx_t[j], 8'h00);
        rdc(EIR_IDX_EVT_STATUS, 8'h00);
        chk(irq, 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
